// [rcf_regs.svh]
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

// Register offsets on the plain register port
`define RCF_ADDR_W          4
`define RCF_OFF_CAUSE       4'h0
`define RCF_OFF_EVT_STAT    4'h1
`define RCF_OFF_EVT_MASK    4'h2

// Reset cause register field positions
`define RCF_BIT_STK_OVF     3'h7
`define RCF_BIT_STK_UNF     3'h6
`define RCF_BIT_EXT_PIN     3'h3
`define RCF_BIT_RST_INSTR   3'h2
`define RCF_BIT_POR         3'h1
`define RCF_BIT_BOR         3'h0

// Reset cause register reset value and implemented bits
`define RCF_CAUSE_RST       8'h0C
`define RCF_CAUSE_IMPL      8'hCF

// Event status and mask bit positions
`define RCF_NUM_EVT         6
`define RCF_EVT_BOR         3'h0
`define RCF_EVT_POR         3'h1
`define RCF_EVT_RST_INSTR   3'h2
`define RCF_EVT_EXT_PIN     3'h3
`define RCF_EVT_STK_UNF     3'h4
`define RCF_EVT_STK_OVF     3'h5
`define RCF_EVT_STAT_RST    6'h00
`define RCF_EVT_MASK_RST    6'h00

`endif

// [rcf_pkg.sv]
package rcf_pkg;

	typedef logic [7:0] rcf_byte_t;
	typedef logic [5:0] rcf_evt_vec_t;

	typedef struct packed {
		logic       stack_overflow_flag;
		logic       stack_underflow_flag;
		logic [1:0] unimpl;
		logic       ext_pin_reset_flag;
		logic       reset_instruction_flag;
		logic       power_on_reset_flag;
		logic       brown_out_reset_flag;
	} rcf_cause_t;

endpackage : rcf_pkg

// [rcf_irq_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface rcf_irq_if;
	rcf_pkg::rcf_evt_vec_t evt;
	rcf_pkg::rcf_evt_vec_t w1c;
	logic                  mask_we;
	rcf_pkg::rcf_evt_vec_t mask_wdata;
	rcf_pkg::rcf_evt_vec_t status;
	rcf_pkg::rcf_evt_vec_t mask;
	logic                  irq;

	modport ctl (
		output evt,
		output w1c,
		output mask_we,
		output mask_wdata,
		input  status,
		input  mask,
		input  irq
	);

	modport irq_side (
		input  evt,
		input  w1c,
		input  mask_we,
		input  mask_wdata,
		output status,
		output mask,
		output irq
	);
endinterface : rcf_irq_if

`default_nettype wire

// [rcf_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module rcf_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
	input  wire logic             core_clk_i,
	input  wire logic             arst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			logic meta_r;
			logic stable_r;
			// First stage feeds only the second stage
			always_ff @(posedge core_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					meta_r   <= RST_VAL[g];
					stable_r <= RST_VAL[g];
				end
				else
				begin
					meta_r   <= async_i[g];
					stable_r <= meta_r;
				end
			end
			assign sync_o[g] = stable_r;
		end
	endgenerate

endmodule : rcf_sync

`default_nettype wire

// [rcf_evt_irq.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rcf_regs.svh"

module rcf_evt_irq (
	input  wire logic core_clk_i,
	input  wire logic arst_n_i,
	rcf_irq_if.irq_side bus
);

	rcf_pkg::rcf_evt_vec_t status_r;
	rcf_pkg::rcf_evt_vec_t mask_r;

	// New event beats a write-one-to-clear in the same cycle
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			status_r <= `RCF_EVT_STAT_RST;
		else
			status_r <= (status_r & ~bus.w1c) | bus.evt;
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			mask_r <= `RCF_EVT_MASK_RST;
		else if (bus.mask_we)
			mask_r <= bus.mask_wdata;
	end

	assign bus.status = status_r;
	assign bus.mask   = mask_r;
	assign bus.irq    = |(status_r & mask_r);

	property p_evt_sticky;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(bus.evt != 6'h00) |=> ((status_r & $past(bus.evt)) == $past(bus.evt));
	endproperty
	a_evt_sticky : assert property (p_evt_sticky)
		else $error("event status bit not set after its event");

endmodule : rcf_evt_irq

`default_nettype wire

// [rcf_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rcf_regs.svh"

module rcf_top (
	input  wire logic                   core_clk_i,
	input  wire logic                   arst_n_i,
	input  wire logic [`RCF_ADDR_W-1:0] addr_i,
	input  wire logic [7:0]             wr_data_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [7:0]             rd_data_o,
	input  wire logic                   stk_ovf_evt_i,
	input  wire logic                   stk_unf_evt_i,
	input  wire logic                   reset_instr_evt_i,
	input  wire logic                   por_evt_i,
	input  wire logic                   bor_evt_i,
	input  wire logic                   external_reset_pin_n_i,
	output logic      [7:0]             cause_flags_o,
	output logic                        irq_o
);

	function automatic logic addr_hit(
		input logic [`RCF_ADDR_W-1:0] addr,
		input logic [`RCF_ADDR_W-1:0] offset
	);
		addr_hit = (addr == offset);
	endfunction : addr_hit

	logic                  cause_we;
	logic                  stat_we;
	logic                  mask_we;
	logic                  ovf_r;
	logic                  unf_r;
	logic                  ext_r;
	logic                  ri_r;
	logic                  por_r;
	logic                  bor_r;
	logic                  pin_n_sync;
	logic                  pin_n_hist_r;
	logic                  ext_evt;
	rcf_pkg::rcf_cause_t   cause;
	rcf_pkg::rcf_byte_t    rd_mux;
	rcf_pkg::rcf_byte_t    rd_data_r;
	rcf_pkg::rcf_evt_vec_t evt_vec;

	rcf_irq_if irq_bus ();

	assign cause_we = wr_i && addr_hit(addr_i, `RCF_OFF_CAUSE);
	assign stat_we  = wr_i && addr_hit(addr_i, `RCF_OFF_EVT_STAT);
	assign mask_we  = wr_i && addr_hit(addr_i, `RCF_OFF_EVT_MASK);

	// External reset pin is asynchronous to the core clock
	rcf_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b1)
	) u_pin_sync (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.async_i    (external_reset_pin_n_i),
		.sync_o     (pin_n_sync)
	);

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			pin_n_hist_r <= 1'b1;
		else
			pin_n_hist_r <= pin_n_sync;
	end

	// One pulse per assertion, so a held pin does not fight firmware
	assign ext_evt = pin_n_hist_r && !pin_n_sync;

	// Flags are only reset by the block's own power-up reset, so the
	// cause survives the system resets it is meant to record.
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ovf_r <= 1'(`RCF_CAUSE_RST >> `RCF_BIT_STK_OVF);
		else if (stk_ovf_evt_i)
			ovf_r <= 1'b1;
		else if (cause_we)
			ovf_r <= wr_data_i[`RCF_BIT_STK_OVF];
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			unf_r <= 1'(`RCF_CAUSE_RST >> `RCF_BIT_STK_UNF);
		else if (stk_unf_evt_i)
			unf_r <= 1'b1;
		else if (cause_we)
			unf_r <= wr_data_i[`RCF_BIT_STK_UNF];
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ext_r <= 1'(`RCF_CAUSE_RST >> `RCF_BIT_EXT_PIN);
		else if (ext_evt)
			ext_r <= 1'b0;
		else if (cause_we)
			ext_r <= wr_data_i[`RCF_BIT_EXT_PIN];
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ri_r <= 1'(`RCF_CAUSE_RST >> `RCF_BIT_RST_INSTR);
		else if (reset_instr_evt_i)
			ri_r <= 1'b0;
		else if (cause_we)
			ri_r <= wr_data_i[`RCF_BIT_RST_INSTR];
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			por_r <= 1'(`RCF_CAUSE_RST >> `RCF_BIT_POR);
		else if (por_evt_i)
			por_r <= 1'b0;
		else if (cause_we)
			por_r <= wr_data_i[`RCF_BIT_POR];
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			bor_r <= 1'(`RCF_CAUSE_RST >> `RCF_BIT_BOR);
		else if (bor_evt_i)
			bor_r <= 1'b0;
		else if (cause_we)
			bor_r <= wr_data_i[`RCF_BIT_BOR];
	end

	always_comb
	begin
		cause                        = '0;
		cause.stack_overflow_flag    = ovf_r;
		cause.stack_underflow_flag   = unf_r;
		cause.unimpl                 = 2'h0;
		cause.ext_pin_reset_flag     = ext_r;
		cause.reset_instruction_flag = ri_r;
		cause.power_on_reset_flag    = por_r;
		cause.brown_out_reset_flag   = bor_r;
	end

	assign cause_flags_o = cause;

	// Every recorded cause also raises a sticky interrupt event
	always_comb
	begin
		evt_vec                     = '0;
		evt_vec[`RCF_EVT_BOR]       = bor_evt_i;
		evt_vec[`RCF_EVT_POR]       = por_evt_i;
		evt_vec[`RCF_EVT_RST_INSTR] = reset_instr_evt_i;
		evt_vec[`RCF_EVT_EXT_PIN]   = ext_evt;
		evt_vec[`RCF_EVT_STK_UNF]   = stk_unf_evt_i;
		evt_vec[`RCF_EVT_STK_OVF]   = stk_ovf_evt_i;
	end

	assign irq_bus.evt        = evt_vec;
	assign irq_bus.w1c        = stat_we ? wr_data_i[`RCF_NUM_EVT-1:0] : 6'h00;
	assign irq_bus.mask_we    = mask_we;
	assign irq_bus.mask_wdata = wr_data_i[`RCF_NUM_EVT-1:0];

	rcf_evt_irq u_evt_irq (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.bus        (irq_bus.irq_side)
	);

	assign irq_o = irq_bus.irq;

	always_comb
	begin
		rd_mux = 8'h00;
		if (addr_hit(addr_i, `RCF_OFF_CAUSE))
			rd_mux = cause & `RCF_CAUSE_IMPL;
		else if (addr_hit(addr_i, `RCF_OFF_EVT_STAT))
			rd_mux = {2'h0, irq_bus.status};
		else if (addr_hit(addr_i, `RCF_OFF_EVT_MASK))
			rd_mux = {2'h0, irq_bus.mask};
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rd_data_r <= 8'h00;
		else if (rd_i)
			rd_data_r <= rd_mux;
		else
			rd_data_r <= 8'h00;
	end

	assign rd_data_o = rd_data_r;

	logic cause_rd_q;
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cause_rd_q <= 1'b0;
		else
			cause_rd_q <= rd_i && addr_hit(addr_i, `RCF_OFF_CAUSE);
	end

	property p_cause_read;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		cause_rd_q |-> (rd_data_o[7] == $past(ovf_r)) && (rd_data_o[6] == $past(unf_r))
			&& (rd_data_o[3] == $past(ext_r)) && (rd_data_o[2] == $past(ri_r))
			&& (rd_data_o[1] == $past(por_r)) && (rd_data_o[0] == $past(bor_r));
	endproperty
	a_cause_read : assert property (p_cause_read)
		else $error("reset cause read data do not match flags");

	property p_ovf_set;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		stk_ovf_evt_i |=> cause_flags_o[7] ##1 (cause_flags_o[7] || $past(cause_we));
	endproperty
	a_ovf_set : assert property (p_ovf_set)
		else $error("stack overflow flag not set or not held");

	property p_unf_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(unf_r && !cause_we) |=> unf_r;
	endproperty
	a_unf_hold : assert property (p_unf_hold)
		else $error("stack underflow flag dropped without a write");

	property p_unimpl_zero;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(rd_i && addr_hit(addr_i, `RCF_OFF_CAUSE)) |=> (rd_data_o[5:4] == 2'h0);
	endproperty
	a_unimpl_zero : assert property (p_unimpl_zero)
		else $error("unimplemented cause bits read nonzero");

	property p_ext_clear;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		($fell(pin_n_sync) && !cause_we) |-> ##1 !ext_r [*1];
	endproperty
	a_ext_clear : assert property (p_ext_clear)
		else $error("external pin reset did not clear its flag");

	property p_ri_clear;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		reset_instr_evt_i |=> !cause_flags_o[2];
	endproperty
	a_ri_clear : assert property (p_ri_clear)
		else $error("reset instruction did not clear its flag");

	property p_por_clear;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		por_evt_i |=> !por_r;
	endproperty
	a_por_clear : assert property (p_por_clear)
		else $error("power-on reset did not clear its flag");

	property p_bor_clear;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		bor_evt_i |=> !bor_r;
	endproperty
	a_bor_clear : assert property (p_bor_clear)
		else $error("brown-out flag set while a brown-out was reported");

	logic stk_ovf_evt_q;
	logic bor_evt_q;
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			stk_ovf_evt_q <= 1'b0;
			bor_evt_q     <= 1'b0;
		end
		else
		begin
			stk_ovf_evt_q <= stk_ovf_evt_i;
			bor_evt_q     <= bor_evt_i;
		end
	end

	property p_hw_wins;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(cause_we && ((stk_ovf_evt_i && !wr_data_i[7]) || (bor_evt_i && wr_data_i[0])))
			|=> (!stk_ovf_evt_q || ovf_r) && (!bor_evt_q || !bor_r);
	endproperty
	a_hw_wins : assert property (p_hw_wins)
		else $error("firmware write overrode a same-cycle hardware event");

	property p_ovf_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(ovf_r && !cause_we) |=> ovf_r;
	endproperty
	a_ovf_hold : assert property (p_ovf_hold)
		else $error("stack overflow flag dropped without a write");

	property p_cause_write;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(cause_we && (evt_vec == 6'h00))
			|=> (cause_flags_o == ($past(wr_data_i) & `RCF_CAUSE_IMPL));
	endproperty
	a_cause_write : assert property (p_cause_write)
		else $error("reset cause write did not land");

	property p_ext_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(!ext_r && !cause_we) |=> !ext_r;
	endproperty
	a_ext_hold : assert property (p_ext_hold)
		else $error("external pin flag set without a write");

	property p_ri_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(!ri_r && !cause_we) |=> !ri_r;
	endproperty
	a_ri_hold : assert property (p_ri_hold)
		else $error("reset instruction flag set without a write");

	property p_por_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(!por_r && !cause_we) |=> !por_r;
	endproperty
	a_por_hold : assert property (p_por_hold)
		else $error("power-on flag set without a write");

	property p_bor_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(!bor_r && !cause_we) |=> !bor_r;
	endproperty
	a_bor_hold : assert property (p_bor_hold)
		else $error("brown-out flag set without a write");

	property p_irq_level;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		irq_o |-> ((irq_bus.status & irq_bus.mask) != 6'h00);
	endproperty
	a_irq_level : assert property (p_irq_level)
		else $error("interrupt high with no unmasked event");

endmodule : rcf_top

`default_nettype wire

// [rcf_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "rcf_regs.svh"

module rcf_top_tb_top;
	logic                   clk;
	logic                   rst_n;
	logic [`RCF_ADDR_W-1:0] addr;
	logic [7:0]             wdat;
	logic                   wr;
	logic                   rd;
	logic [7:0]             rdat;
	logic [5:0]             ev;
	logic                   pin_n;
	logic [7:0]             flags;
	logic                   irq;
	logic [7:0]             exp_val;
	int                     err_total;
	int                     tests_run;
	int                     cnt;
	logic [2:0]             cb [6] = '{`RCF_BIT_BOR, `RCF_BIT_POR, `RCF_BIT_RST_INSTR,
		`RCF_BIT_EXT_PIN, `RCF_BIT_STK_UNF, `RCF_BIT_STK_OVF};

	rcf_top uut (
		.core_clk_i             (clk),
		.arst_n_i               (rst_n),
		.addr_i                 (addr),
		.wr_data_i              (wdat),
		.wr_i                   (wr),
		.rd_i                   (rd),
		.rd_data_o              (rdat),
		.stk_ovf_evt_i          (ev[5]),
		.stk_unf_evt_i          (ev[4]),
		.reset_instr_evt_i      (ev[2]),
		.por_evt_i              (ev[1]),
		.bor_evt_i              (ev[0]),
		.external_reset_pin_n_i (pin_n),
		.cause_flags_o          (flags),
		.irq_o                  (irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	task automatic chk8(input logic [7:0] got, input logic [7:0] want);
		tests_run++;
		if (got !== want)
		begin
			err_total++;
			$display("wrong value at %0t: byte %h expected %h", $time, got, want);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic want);
		tests_run++;
		if (got !== want)
		begin
			err_total++;
			$display("wrong value at %0t: bit %b expected %b", $time, got, want);
		end
	endtask : chk1

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr   <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// Read data stands one cycle only, then must drop to zero
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] want);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk8(rdat, want);
		@(posedge clk);
		#1;
		chk8(rdat, 8'h00);
	endtask : rd_reg

	// Event pulse, optionally with a cause write in the same cycle
	task automatic pulse(input int i, input logic dow, input logic [7:0] d);
		@(posedge clk);
		ev[i] <= 1'b1;
		if (dow)
		begin
			addr <= `RCF_OFF_CAUSE;
			wdat <= d;
			wr   <= 1'b1;
		end
		@(posedge clk);
		ev <= 6'h00;
		wr <= 1'b0;
		#1;
	endtask : pulse

	// Pin passes a synchroniser, so the wait is bounded, not fixed
	task automatic pin_low;
		@(posedge clk);
		pin_n <= 1'b0;
		cnt = 0;
		while (flags[3] !== 1'b0 && cnt < 10)
		begin
			@(posedge clk);
			#1;
			cnt++;
		end
		if (flags[3] !== 1'b0)
		begin
			err_total++;
			$display("wrong value at %0t: pin flag never cleared", $time);
			test_done();
		end
	endtask : pin_low

	initial
	begin
		addr      = 4'h0;
		wdat      = 8'h00;
		wr        = 1'b0;
		rd        = 1'b0;
		ev        = 6'h00;
		pin_n     = 1'b1;
		rst_n     = 1'b0;
		err_total = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk8(flags, `RCF_CAUSE_RST);
		chk1(irq, 1'b0);
		rd_reg(`RCF_OFF_CAUSE, `RCF_CAUSE_RST);
		wr_reg(`RCF_OFF_CAUSE, 8'hFF);
		rd_reg(`RCF_OFF_CAUSE, 8'hCF);
		wr_reg(`RCF_OFF_CAUSE, 8'h00);
		chk8(flags, 8'h00);
		rd_reg(4'hF, 8'h00);
		wr_reg(4'hF, 8'hFF);
		rd_reg(`RCF_OFF_CAUSE, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(`RCF_OFF_CAUSE, 8'h0F);
			wr_reg(`RCF_OFF_EVT_STAT, 8'h3F);
			wr_reg(`RCF_OFF_EVT_MASK, 8'h00);
			if (i == 3)
				pin_low();
			else
				pulse(i, 1'b0, 8'h00);
			exp_val = (i >= 4) ? (8'h0F | (8'h01 << cb[i])) : (8'h0F & ~(8'h01 << cb[i]));
			chk8(flags, exp_val);
			chk1(irq, 1'b0);
			rd_reg(`RCF_OFF_EVT_STAT, 8'h01 << i);
			wr_reg(`RCF_OFF_EVT_MASK, 8'h01 << i);
			chk1(irq, 1'b1);
			wr_reg(`RCF_OFF_EVT_STAT, 8'h01 << i);
			chk1(irq, 1'b0);
			if (i == 3)
			begin
				// A pin held low must not clear the flag again
				wr_reg(`RCF_OFF_CAUSE, 8'h0F);
				repeat (5) @(posedge clk);
				#1;
				chk8(flags, 8'h0F);
				@(posedge clk);
				pin_n <= 1'b1;
			end
		end
		pulse(5, 1'b1, 8'h00);
		chk8(flags, 8'h80);
		pulse(1, 1'b1, 8'hFF);
		chk8(flags, 8'hCD);
		pulse(4, 1'b0, 8'h00);
		rd_reg(`RCF_OFF_CAUSE, 8'hCD);
		test_done();
	end
endmodule : rcf_top_tb_top

`default_nettype wire
